/* common/adcsr_pkg.sv */
// adcsr_pkg: constants and carrier types for the converter serial readout port
// assumes a 40 MHz mclk and a host shift clock well below it (bench: 200 ns)
package adcsr_pkg;

    localparam int unsigned RESULT_BITS     = 16;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    // internal shift clock half period, in ns and in mclk cycles
    localparam int unsigned INT_HALF_NS     = 100;
    localparam int unsigned INT_HALF_CYC    = (INT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  BIT_LAST        = 4'h0;
    localparam logic [15:0] RESULT_RST      = 16'h0000;

    // interrupt status bit positions
    localparam int unsigned EV_FRAME_DONE   = 0;
    localparam int unsigned EV_OVERRUN      = 1;
    localparam int unsigned EV_WIDTH        = 2;

    // register indices on the plain port
    localparam logic [1:0]  REG_STATUS      = 2'h0;
    localparam logic [1:0]  REG_CLEAR       = 2'h1;
    localparam logic [1:0]  REG_ENABLE      = 2'h2;
    localparam logic [1:0]  REG_RESULT      = 2'h3;
    localparam logic [1:0]  EV_ENABLE_RST   = 2'h0;

    // static configuration straps of the serial port
    typedef struct packed {
        logic port_select;          // high: serial mode
        logic clock_source_select;  // high: host supplies shift clock
        logic frame_sync_polarity;  // high: frame sync active low
        logic shift_clock_invert;   // high: update on falling host clock edge, rising internal clock pin edge
        logic output_coding_select; // high: straight binary
    } adcsr_cfg_t;

    // conversion side handshake from the converter core
    typedef struct packed {
        logic        conv_active;   // conversion in progress
        logic        conv_done;     // one-cycle pulse: result latched
        logic [15:0] result;
    } adcsr_conv_t;

endpackage : adcsr_pkg

/* rtl/adcsr_sync.sv */
// adcsr_sync: two flip-flop level synchroniser, WIDTH bits
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module adcsr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : adcsr_sync
`default_nettype wire

/* rtl/adcsr_port.sv */
// adcsr_port: serial readout port of a 16-bit converter sharing the parallel pins
// assumes conv carrier comes from the converter core on mclk; pins are asynchronous
//
// Overview of operation
// - with port_select low, shared pins carry parallel result bits 7 to 10.
// - external clock in serial mode makes the mode pin a chain input.
// - chain input level appears on serial_out sixteen shift clocks after read start.
// - internal clock, read mode high: shift out while next conversion runs.
// - internal clock, read mode low: shift out only after conversion finished.
// - result leaves the shift register most significant bit first.
// - output_coding_select picks the coding of the serial result.
// - coding high is straight binary; low inverts the msb, two's complement.
// - with internal clock and no invert each bit changes on the falling internal clock edge and is stable across the rising one.
// - external clock, no invert: update on rising edge, host samples falling.
// - external clock, invert: update on falling edge, host samples rising.
// - shift clock pin direction follows clock source; invert picks the edge.
// - clock source low drives internal clock out; high the host drives it.
// - frame sync is only produced with the internal shift clock.
// - polarity low: frame sync high while serial output data are valid.
// - polarity high: frame sync low while serial output data are valid.
// - external clock read unfinished at next conversion end: drop data, pulse overrun.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module adcsr_port
    import adcsr_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire adcsr_pkg::adcsr_cfg_t cfg,
    input  wire adcsr_pkg::adcsr_conv_t conv,
    input  wire logic                  pin_d7_in,
    input  wire logic                  pin_d9_in,
    output logic                       pin_d7_out,
    output logic                       pin_d7_oe,
    output logic                       pin_d8_out,
    output logic                       pin_d9_out,
    output logic                       pin_d9_oe,
    output logic                       pin_d10_out,
    input  wire logic [1:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [15:0]           reg_rdata,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and configuration decode

    logic [1:0] pins_s;
    logic       chain_s;
    logic       sclk_s;
    logic       sclk_prev_q;

    adcsr_sync #(.WIDTH(2)) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({pin_d7_in, pin_d9_in}),
        .sync_out (pins_s)
    );
    assign chain_s = pins_s[1];
    assign sclk_s  = pins_s[0];

    logic serial_mode;
    logic ext_clk;
    logic read_mode_or_chain_in;

    assign serial_mode           = cfg.port_select;
    assign ext_clk               = serial_mode && cfg.clock_source_select;
    assign read_mode_or_chain_in = chain_s;

    function automatic logic [15:0] code_result(input logic [15:0] raw, input logic straight);
        code_result = straight ? raw : {~raw[15], raw[14:0]};
    endfunction : code_result

    ////////////////////////////////////////////////////////////////////////////
    // shift clock edges: host clock sampled, or internal divider

    logic       ext_rise;
    logic       ext_fall;
    logic       ext_update;
    logic [2:0] div_cnt_q;
    logic       int_sclk_q;
    logic       int_tick;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    assign ext_rise   = sclk_s && !sclk_prev_q;
    assign ext_fall   = !sclk_s && sclk_prev_q;
    assign ext_update = cfg.shift_clock_invert ? ext_fall : ext_rise;
    assign int_tick = (div_cnt_q == 3'(INT_HALF_CYC - 1));

    ////////////////////////////////////////////////////////////////////////////
    // frame state machine

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT} adcsr_state_t;
    adcsr_state_t state_q;
    logic [15:0]  shreg_q;
    logic [15:0]  result_q;
    logic [4:0]   bits_left_q;
    logic         pending_q;
    logic         overrun_q;
    logic         frame_done;
    logic         int_start;

    // internal read start: read mode high shifts during conversion, low waits for idle
    assign int_start = pending_q && (read_mode_or_chain_in ? 1'b1 : !conv.conv_active);

    always_ff @(posedge mclk)
    begin
        if (!rst_n || state_q != ST_SHIFT || ext_clk)
        begin
            div_cnt_q  <= '0;
            int_sclk_q <= 1'b0;
        end
        else
        begin
            div_cnt_q <= int_tick ? 3'h0 : div_cnt_q + 3'h1;
            if (int_tick)
                int_sclk_q <= ~int_sclk_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            result_q  <= RESULT_RST;
            pending_q <= 1'b0;
        end
        else if (conv.conv_done)
        begin
            result_q  <= conv.result;
            pending_q <= 1'b1;
        end
        else if (state_q == ST_WAIT && !ext_clk && int_start)
            pending_q <= 1'b0;
        else if (state_q == ST_IDLE && ext_clk)
            pending_q <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q     <= ST_IDLE;
            shreg_q     <= RESULT_RST;
            bits_left_q <= '0;
            overrun_q   <= 1'b0;
        end
        else
        begin
            overrun_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (serial_mode && (conv.conv_done || pending_q))
                        state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (!serial_mode)
                        state_q <= ST_IDLE;
                    else if (ext_clk || int_start)
                    begin
                        shreg_q     <= code_result(result_q, cfg.output_coding_select);
                        bits_left_q <= 5'(RESULT_BITS);
                        state_q     <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (!serial_mode)
                        state_q <= ST_IDLE;
                    else if (ext_clk && conv.conv_done && bits_left_q != 5'h0 && bits_left_q != 5'(RESULT_BITS))
                    begin
                        overrun_q <= 1'b1;
                        shreg_q     <= code_result(conv.result, cfg.output_coding_select);
                        bits_left_q <= 5'(RESULT_BITS);
                    end
                    else if (ext_clk ? ext_update : (int_tick && int_sclk_q))
                    begin
                        // internal mode changes on the falling clock so the rising edge sees a stable bit
                        shreg_q <= {shreg_q[14:0], ext_clk ? chain_s : 1'b0};
                        if (bits_left_q != 5'h0)
                            bits_left_q <= bits_left_q - 5'h1;
                        if (!ext_clk && bits_left_q == 5'h1)
                            state_q <= ST_IDLE;
                    end
                    else if (ext_clk && conv.conv_done)
                    begin
                        shreg_q     <= code_result(conv.result, cfg.output_coding_select);
                        bits_left_q <= 5'(RESULT_BITS);
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign frame_done = (state_q == ST_SHIFT) && (bits_left_q == 5'h1)
                      && (ext_clk ? ext_update : (int_tick && int_sclk_q));

    ////////////////////////////////////////////////////////////////////////////
    // shared pin drivers

    logic sync_active;
    assign sync_active = (state_q == ST_SHIFT) && !ext_clk;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_d7_out  <= 1'b0;
            pin_d7_oe   <= 1'b1;
            pin_d8_out  <= 1'b0;
            pin_d9_out  <= 1'b0;
            pin_d9_oe   <= 1'b1;
            pin_d10_out <= 1'b0;
        end
        else if (!serial_mode)
        begin
            pin_d7_out  <= result_q[7];
            pin_d7_oe   <= 1'b1;
            pin_d8_out  <= result_q[8];
            pin_d9_out  <= result_q[9];
            pin_d9_oe   <= 1'b1;
            pin_d10_out <= result_q[10];
        end
        else
        begin
            pin_d7_out  <= 1'b0;
            pin_d7_oe   <= 1'b0;
            pin_d8_out  <= shreg_q[15];
            pin_d9_out  <= int_sclk_q ^ cfg.shift_clock_invert;
            pin_d9_oe   <= !cfg.clock_source_select;
            pin_d10_out <= ext_clk ? 1'b0 : (sync_active ^ cfg.frame_sync_polarity);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags and register port

    logic [EV_WIDTH-1:0] ev_status_q;
    logic [EV_WIDTH-1:0] ev_enable_q;
    logic [EV_WIDTH-1:0] ev_set;
    logic [EV_WIDTH-1:0] ev_clr;

    assign ev_set = {overrun_q, frame_done};
    assign ev_clr = (reg_wr && reg_addr == REG_CLEAR) ? reg_wdata[EV_WIDTH-1:0] : '0;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ev_status_q <= '0;
        else
            ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ev_enable_q <= EV_ENABLE_RST;
        else if (reg_wr && reg_addr == REG_ENABLE)
            ev_enable_q <= reg_wdata[EV_WIDTH-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            irq <= |(((ev_status_q & ~ev_clr) | ev_set) & ev_enable_q);
            if (reg_rd)
            begin
                case (reg_addr)
                    REG_STATUS: reg_rdata <= {14'h0000, ev_status_q};
                    REG_ENABLE: reg_rdata <= {14'h0000, ev_enable_q};
                    REG_RESULT: reg_rdata <= result_q;
                    default:    reg_rdata <= '0;
                endcase
            end
            else
                reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_overrun_cause;
        ext_clk && state_q == ST_SHIFT && conv.conv_done
            && bits_left_q != 5'h0 && bits_left_q != 5'(RESULT_BITS);
    endsequence

    a_overrun_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        s_overrun_cause |=> overrun_q ##1 !overrun_q)
        else $error("overrun not pulsed for one cycle");
    a_parallel_bit7: assert property (@(posedge mclk) disable iff (!rst_n)
        !serial_mode |=> pin_d7_out == $past(result_q[7]) && pin_d7_oe)
        else $error("bit 7 not on shared pin in parallel mode");
    a_sclk_direction: assert property (@(posedge mclk) disable iff (!rst_n)
        serial_mode |=> pin_d9_oe == !$past(cfg.clock_source_select))
        else $error("shift clock direction wrong");
    a_sync_idle_ext: assert property (@(posedge mclk) disable iff (!rst_n)
        ext_clk |=> !pin_d10_out)
        else $error("frame sync driven with host clock");
    a_sync_level: assert property (@(posedge mclk) disable iff (!rst_n)
        (serial_mode && !ext_clk) |=> pin_d10_out == ($past(sync_active) ^ $past(cfg.frame_sync_polarity)))
        else $error("frame sync level wrong");
    a_msb_first: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_WAIT && serial_mode && !ext_clk && int_start)
            |=> shreg_q[15] == ($past(result_q[15]) ^ !$past(cfg.output_coding_select)))
        else $error("msb or coding wrong at frame start");
    a_wait_conv: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_WAIT && !ext_clk && !read_mode_or_chain_in && conv.conv_active) |=> state_q != ST_SHIFT)
        else $error("shift began during conversion");
    a_int_bit_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_SHIFT && !ext_clk && int_tick && !int_sclk_q) |=> $stable(shreg_q))
        else $error("bit changed on rising internal clock");
    a_chain_shift: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_SHIFT && ext_clk && ext_update && !conv.conv_done) |=> shreg_q[0] == $past(chain_s))
        else $error("chain input not shifted in");

endmodule : adcsr_port
`default_nettype wire

/* testbench/adcsr_host_model.sv */
// adcsr_host_model: host serial port on the far side of the readout port
// assumes the bench mclk; the host shift clock is made with delays, unrelated to mclk
`timescale 1ns/1ps
`default_nettype none
module adcsr_host_model (
    input  wire logic                  mclk,
    input  wire adcsr_pkg::adcsr_cfg_t cfg,
    input  wire logic                  sdata,
    input  wire logic                  sclk_pin,
    input  wire logic                  fsync,
    output logic                       sclk_host,
    output logic [31:0]                rx,
    output int                         nrx
);
    logic ext;
    logic inv;
    logic pol;
    logic sclk_prev;

    assign ext = cfg.clock_source_select;
    assign inv = cfg.shift_clock_invert;
    assign pol = cfg.frame_sync_polarity;

    initial
    begin
        sclk_host = 1'b1;
        rx        = '0;
        nrx       = 0;
        sclk_prev = 1'b0;
    end

    // device clock: take a bit on each sampling edge while frame sync is active
    always @(posedge mclk)
    begin
        sclk_prev <= sclk_pin;
        if (!ext && fsync != pol && sclk_pin != sclk_prev && sclk_pin != inv)
        begin
            rx  <= {rx[30:0], sdata};
            nrx <= nrx + 1;
        end
    end

    // clock stands at the level whose first edge is the sampling edge
    task automatic idle(input logic invert);
        sclk_host = !invert;
        rx        = '0;
        nrx       = 0;
    endtask : idle

    // short sampling phase, long update phase: the synced update lands well before the next sample
    task automatic run_frame(input int n);
        #7;
        repeat (n)
        begin
            sclk_host = inv;
            rx        = {rx[30:0], sdata};
            nrx       = nrx + 1;
            #50;
            sclk_host = !inv;
            #150;
        end
    endtask : run_frame
endmodule : adcsr_host_model
`default_nettype wire

/* testbench/adcsr_port_tb_top.sv */
// adcsr_port_tb_top: self-checking bench for the converter serial readout port
// assumes adcsr_pkg and the host model; straps change only around a reset
`timescale 1ns/1ps
`default_nettype none
module adcsr_port_tb_top;
    import adcsr_pkg::*;

    typedef struct packed {
        logic        ps;
        logic        ext;
        logic        inv;
        logic        pol;
        logic        code;
        logic [15:0] res;
        logic        chain;
    } adcsr_row_t;

    logic        mclk, rst_n, pin_d7_in, pin_d9_in, reg_wr, reg_rd, irq;
    logic        pin_d7_out, pin_d7_oe, pin_d8_out, pin_d9_out, pin_d9_oe, pin_d10_out;
    adcsr_cfg_t  cfg;
    adcsr_conv_t conv;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [15:0] reg_rdata, rdv, exp_w;
    logic [31:0] rx;
    int          nrx, mismatches, samples_checked, cycles;
    adcsr_row_t  r;
    adcsr_row_t  rows [8] = '{
        {1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'hA5C3, 1'b0},
        {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0780, 1'b0},
        {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h8001, 1'b0},
        {1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h8001, 1'b0},
        {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h7FFE, 1'b0},
        {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 16'hC3A5, 1'b1},
        {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 1'b0},
        {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'hFFFE, 1'b1}};

    adcsr_port DUT (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .conv(conv), .pin_d7_in(pin_d7_in),
        .pin_d9_in(pin_d9_in), .pin_d7_out(pin_d7_out), .pin_d7_oe(pin_d7_oe), .pin_d8_out(pin_d8_out),
        .pin_d9_out(pin_d9_out), .pin_d9_oe(pin_d9_oe), .pin_d10_out(pin_d10_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    adcsr_host_model host (.mclk(mclk), .cfg(cfg), .sdata(pin_d8_out), .sclk_pin(pin_d9_out),
        .fsync(pin_d10_out), .sclk_host(pin_d9_in), .rx(rx), .nrx(nrx));

    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : reg_read

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : do_reset

    task automatic load(input logic [15:0] res, input logic active);
        conv <= {active, 1'b1, res};
        @(posedge mclk);
        conv.conv_done <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : load

    task automatic wait_int_frame();
        int k;
        k = 0;
        while (k < 400 && !(nrx >= 16 && pin_d10_out === cfg.frame_sync_polarity))
        begin
            @(posedge mclk);
            k++;
        end
    endtask : wait_int_frame

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        cfg = '0;
        conv = '0;
        pin_d7_in = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        reg_read(REG_STATUS, rdv);
        check(rdv, 16'h0000);
        reg_read(REG_ENABLE, rdv);
        check(rdv, 16'h0000);
        reg_read(REG_RESULT, rdv);
        check(rdv, RESULT_RST);
        reg_read(REG_CLEAR, rdv);
        check(rdv, 16'h0000);
        check(irq, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            exp_w = r.code ? r.res : r.res ^ 16'h8000;
            cfg <= {r.ps, r.ext, r.pol, r.inv, r.code};
            pin_d7_in <= r.ext ? r.chain : 1'b1;
            host.idle(r.inv);
            do_reset();
            check(pin_d7_oe, !r.ps);
            check(pin_d9_oe, !(r.ps && r.ext));
            if (r.ps)
                check(pin_d10_out, r.ext ? 1'b0 : r.pol);
            load(r.res, 1'b0);
            if (!r.ps)
                check({pin_d10_out, pin_d9_out, pin_d8_out, pin_d7_out}, r.res[10:7]);
            else if (r.ext)
            begin
                host.run_frame(17);
                @(posedge mclk);
                check(rx[16:0], {exp_w, r.chain});
            end
            else
            begin
                wait_int_frame();
                check(rx[15:0], exp_w);
                check(nrx, 16);
            end
            $display("test row %0d done", i);
        end
        cfg <= {1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        pin_d7_in <= 1'b0;
        host.idle(1'b0);
        do_reset();
        load(16'h4321, 1'b1);
        repeat (40) @(posedge mclk);
        check(pin_d10_out, 1'b0);
        check(nrx, 0);
        conv.conv_active <= 1'b0;
        wait_int_frame();
        check(rx[15:0], 16'h4321);
        pin_d7_in <= 1'b1;
        host.idle(1'b0);
        repeat (4) @(posedge mclk);
        load(16'h5AA5, 1'b1);
        wait_int_frame();
        check(rx[15:0], 16'h5AA5);
        conv.conv_active <= 1'b0;
        $display("test read mode done");
        cfg <= {1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        pin_d7_in <= 1'b0;
        host.idle(1'b0);
        do_reset();
        load(16'hBEEF, 1'b0);
        host.run_frame(5);
        @(posedge mclk);
        load(16'h0F0F, 1'b0);
        reg_read(REG_STATUS, rdv);
        check(rdv, 16'h0002);
        reg_read(REG_RESULT, rdv);
        check(rdv, 16'h0F0F);
        host.idle(1'b0);
        host.run_frame(16);
        @(posedge mclk);
        check(rx[15:0], 16'h0F0F);
        repeat (4) @(posedge mclk);
        check(irq, 1'b0);
        reg_write(REG_ENABLE, 8'h03);
        repeat (3) @(posedge mclk);
        check(irq, 1'b1);
        reg_write(REG_CLEAR, 8'h01);
        reg_read(REG_STATUS, rdv);
        check(rdv, 16'h0002);
        reg_write(REG_ENABLE, 8'h01);
        repeat (3) @(posedge mclk);
        check(irq, 1'b0);
        reg_read(REG_ENABLE, rdv);
        check(rdv, 16'h0001);
        reg_write(REG_CLEAR, 8'h02);
        reg_read(REG_STATUS, rdv);
        check(rdv, 16'h0000);
        $display("test overrun done");
        tally_and_finish();
    end
endmodule : adcsr_port_tb_top
`default_nettype wire
